// *** fpbw_cfg.svh ***
// Configuration macros for the flash page/block write buffer
`ifndef FPBW_CFG_SVH
`define FPBW_CFG_SVH
`define FPBW_ADDR_STATUS 32'h0000_0000
`define FPBW_ADDR_CTRL 32'h0000_0004
`define FPBW_ADDR_IRQ_STAT 32'h0000_0008
`define FPBW_ADDR_IRQ_CLR 32'h0000_000c
`define FPBW_ADDR_IRQ_EN 32'h0000_0010
`define FPBW_ADDR_LOCK_LO 32'h0000_0014
`define FPBW_CTRL_GUARD_BIT 0
`define FPBW_CTRL_DISCARD_BIT 1
`define FPBW_CTRL_PROGRAM_BIT 2
`define FPBW_CTRL_LOCKPGM_BIT 3
`define FPBW_CTRL_UNPROT_BIT 4
`define FPBW_ST_OK 2'h0
`define FPBW_ST_LOCKED 2'h1
`define FPBW_ST_GUARD 2'h3
`define FPBW_SZ_1 2'h0
`define FPBW_SZ_2 2'h1
`endif

// *** fpbw_pkg.sv ***
// Types for the flash page/block write buffer
package fpbw_pkg;
  typedef enum logic [2:0] {
    FPBW_IDLE, FPBW_PG_RD, FPBW_PG_WAIT, FPBW_BLK_LD, FPBW_MERGE, FPBW_PGM, FPBW_PGM_WAIT
  } fpbw_state_t;
  // One user write request
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [1:0] size;
  } fpbw_wreq_t;
  // Events latched into the interrupt status register
  typedef struct packed {
    logic pgm_done;
    logic refused;
    logic wr_done;
  } fpbw_evt_t;
endpackage : fpbw_pkg

// *** fpbw_write_buffer.sv ***
// Flash page/block write buffer with APB control and status
`timescale 1ns/1ps
`include "fpbw_cfg.svh"
module fpbw_write_buffer import fpbw_pkg::*; #(
  parameter int BLK_BYTES = 16, // Bytes per block
  parameter int PG_BYTES = 128, // Bytes per page
  parameter int PAGES = 32 // Pages in the array
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [31:0] wr_addr,
  input wire logic [31:0] write_data_in,
  input wire logic [1:0] transfer_size_sel,
  output logic [1:0] wr_status,
  output logic wr_done,
  output logic arr_rd_req,
  output logic arr_pgm_req,
  output logic [31:0] arr_page_addr,
  output logic [PG_BYTES*8-1:0] arr_wdata,
  input wire logic arr_ack,
  input wire logic [PG_BYTES*8-1:0] arr_rdata,
  output logic irq
);
  localparam int BW = $clog2(BLK_BYTES);
  localparam int PW = $clog2(PG_BYTES);
  localparam int NB = PG_BYTES / BLK_BYTES;
  // Refuse geometries the byte-lane and lock-bit logic cannot serve, at elaboration
  if (BLK_BYTES < 4 || PG_BYTES < BLK_BYTES || (1 << BW) != BLK_BYTES || (1 << PW) != PG_BYTES
      || PAGES > 32 || PAGES < 1) begin : g_geom_bad
    $error("fpbw: unsupported buffer geometry");
  end

  fpbw_state_t state_ff; // Sequencer state
  logic [7:0] page_ff [PG_BYTES]; // Page buffer
  logic [7:0] blk_ff [BLK_BYTES]; // Block buffer
  logic [31:0] cur_page_ff; // Page held in page buffer
  logic page_vld_ff; // Page buffer holds a page
  logic [31:0] cur_blk_ff; // Block index held in block buffer
  logic blk_vld_ff; // Block buffer valid
  fpbw_wreq_t req_ff; // Accepted request
  logic [31:0] lock_ff; // Per-page lock bits
  logic guard_ff; // Page retain guard
  logic lockpgm_ff; // Lock page on next program
  logic [1:0] status_ff; // Last status code
  fpbw_evt_t ist_ff; // Sticky events
  fpbw_evt_t ien_ff; // Event enables
  logic done_ff; // Write completion pulse
  logic pgm_done_ff; // Program completion pulse
  logic refuse_ff; // Refusal pulse
  logic dirty_ff; // Page buffer holds writes not yet programmed; guard only bites then

  // Decode the incoming request
  logic [31:0] in_page;
  logic [31:0] in_blk;
  logic in_locked;
  assign in_page = wr_addr >> PW;
  assign in_blk = 32'(wr_addr[PW-1:0] >> BW);
  assign in_locked = lock_ff[in_page[4:0]] && in_page < PAGES;
  assign wr_ready = (state_ff == FPBW_IDLE);

  // APB decode: zero wait states, error on unmapped addresses
  logic apb_wr;
  logic apb_rd;
  logic mapped;
  assign mapped = paddr inside {`FPBW_ADDR_STATUS, `FPBW_ADDR_CTRL, `FPBW_ADDR_IRQ_STAT, `FPBW_ADDR_IRQ_CLR,
                                `FPBW_ADDR_IRQ_EN, `FPBW_ADDR_LOCK_LO};
  assign apb_wr = psel && penable && pwrite && mapped;
  assign apb_rd = psel && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  logic ctl_prog;
  logic ctl_disc;
  logic ctl_unprot;
  assign ctl_prog = apb_wr && paddr == `FPBW_ADDR_CTRL && pwdata[`FPBW_CTRL_PROGRAM_BIT];
  assign ctl_disc = apb_wr && paddr == `FPBW_ADDR_CTRL && pwdata[`FPBW_CTRL_DISCARD_BIT];
  assign ctl_unprot = apb_wr && paddr == `FPBW_ADDR_CTRL && pwdata[`FPBW_CTRL_UNPROT_BIT];

  // Read data mux, registered so data is a flop output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (apb_rd && !penable) begin
      case (paddr)
        `FPBW_ADDR_STATUS: prdata <= {27'h0, blk_vld_ff, page_vld_ff, (state_ff != FPBW_IDLE), status_ff};
        `FPBW_ADDR_CTRL: prdata <= {28'h0, lockpgm_ff, 2'h0, guard_ff};
        `FPBW_ADDR_IRQ_STAT: prdata <= {29'h0, ist_ff};
        `FPBW_ADDR_IRQ_EN: prdata <= {29'h0, ien_ff};
        `FPBW_ADDR_LOCK_LO: prdata <= lock_ff;
        default: prdata <= 32'h0; // Clear register and unmapped read as zero
      endcase
    end
  end

  // Control bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      guard_ff <= 1'b0;
      lockpgm_ff <= 1'b0;
      ien_ff <= '0;
    end else if (apb_wr && paddr == `FPBW_ADDR_CTRL) begin
      guard_ff <= pwdata[`FPBW_CTRL_GUARD_BIT];
      lockpgm_ff <= pwdata[`FPBW_CTRL_LOCKPGM_BIT];
    end else if (apb_wr && paddr == `FPBW_ADDR_IRQ_EN) begin
      ien_ff <= fpbw_evt_t'(pwdata[2:0]);
    end
  end

  // Sticky events; a new event wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_ff <= '0;
    end else begin
      ist_ff <= (apb_wr && paddr == `FPBW_ADDR_IRQ_CLR) ? (ist_ff & ~fpbw_evt_t'(pwdata[2:0])) : ist_ff;
      if (done_ff) ist_ff.wr_done <= 1'b1;
      if (refuse_ff) ist_ff.refused <= 1'b1;
      if (pgm_done_ff) ist_ff.pgm_done <= 1'b1;
    end
  end
  assign irq = |(ist_ff & ien_ff);

  // Main sequencer: fetch page, load block, merge, copy back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= FPBW_IDLE;
      req_ff <= '0;
      cur_page_ff <= 32'h0;
      page_vld_ff <= 1'b0;
      cur_blk_ff <= 32'h0;
      blk_vld_ff <= 1'b0;
      status_ff <= `FPBW_ST_OK;
      lock_ff <= 32'h0;
      done_ff <= 1'b0;
      pgm_done_ff <= 1'b0;
      refuse_ff <= 1'b0;
      dirty_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      pgm_done_ff <= 1'b0;
      refuse_ff <= 1'b0;
      case (state_ff)
        FPBW_IDLE: begin
          if (ctl_disc) begin
            page_vld_ff <= 1'b0;
            blk_vld_ff <= 1'b0;
            dirty_ff <= 1'b0;
            status_ff <= `FPBW_ST_OK;
          end else if (ctl_unprot) begin
            lock_ff[cur_page_ff[4:0]] <= 1'b0;
          end else if (ctl_prog && page_vld_ff) begin
            if (lock_ff[cur_page_ff[4:0]]) begin
              status_ff <= `FPBW_ST_LOCKED;
              refuse_ff <= 1'b1;
            end else begin
              state_ff <= FPBW_PGM;
            end
          end else if (wr_valid) begin
            req_ff <= '{addr: wr_addr, data: write_data_in, size: transfer_size_sel};
            if (in_locked) begin
              status_ff <= `FPBW_ST_LOCKED;
              refuse_ff <= 1'b1;
            end else if (page_vld_ff && dirty_ff && in_page != cur_page_ff && guard_ff) begin
              status_ff <= `FPBW_ST_GUARD;
              refuse_ff <= 1'b1;
            end else if (!page_vld_ff || in_page != cur_page_ff) begin
              cur_page_ff <= in_page;
              blk_vld_ff <= 1'b0;
              status_ff <= `FPBW_ST_OK;
              state_ff <= FPBW_PG_RD;
            end else if (blk_vld_ff && in_blk == cur_blk_ff) begin
              status_ff <= `FPBW_ST_OK;
              state_ff <= FPBW_MERGE;
            end else begin
              status_ff <= `FPBW_ST_OK;
              state_ff <= FPBW_BLK_LD;
            end
          end
        end
        FPBW_PG_RD: state_ff <= FPBW_PG_WAIT;
        FPBW_PG_WAIT: begin
          if (arr_ack) begin
            page_vld_ff <= 1'b1;
            state_ff <= FPBW_BLK_LD;
          end
        end
        FPBW_BLK_LD: begin
          cur_blk_ff <= 32'(req_ff.addr[PW-1:0] >> BW);
          blk_vld_ff <= 1'b1;
          state_ff <= FPBW_MERGE;
        end
        FPBW_MERGE: begin
          done_ff <= 1'b1;
          dirty_ff <= 1'b1;
          state_ff <= FPBW_IDLE;
        end
        FPBW_PGM: state_ff <= FPBW_PGM_WAIT;
        FPBW_PGM_WAIT: begin
          if (arr_ack) begin
            if (lockpgm_ff) lock_ff[cur_page_ff[4:0]] <= 1'b1;
            pgm_done_ff <= 1'b1;
            dirty_ff <= 1'b0;
            state_ff <= FPBW_IDLE;
          end
        end
        default: state_ff <= FPBW_IDLE;
      endcase
    end
  end

  // Byte lanes written by the request; low address bits dropped by size
  logic [BW-1:0] lane_base;
  logic [2:0] lane_cnt;
  always_comb begin
    lane_base = req_ff.addr[BW-1:0];
    lane_cnt = 3'h4;
    case (req_ff.size)
      `FPBW_SZ_1: lane_cnt = 3'h1;
      `FPBW_SZ_2: begin
        lane_cnt = 3'h2;
        lane_base[0] = 1'b0;
      end
      default: lane_base[1:0] = 2'h0;
    endcase
  end

  // Buffer storage: page fill, block load and merge
  always_ff @(posedge pclk) begin
    if (state_ff == FPBW_PG_WAIT && arr_ack) begin
      for (int i = 0; i < PG_BYTES; i++) page_ff[i] <= arr_rdata[i*8 +: 8];
    end else if (state_ff == FPBW_BLK_LD) begin
      for (int i = 0; i < BLK_BYTES; i++)
        blk_ff[i] <= page_ff[{req_ff.addr[PW-1:BW], BW'(i)}];
    end else if (state_ff == FPBW_MERGE) begin
      for (int i = 0; i < 4; i++) begin
        if (3'(i) < lane_cnt) begin
          blk_ff[lane_base + BW'(i)] <= req_ff.data[i*8 +: 8];
          page_ff[{req_ff.addr[PW-1:BW], BW'(lane_base + BW'(i))}] <= req_ff.data[i*8 +: 8];
        end
      end
    end
  end

  // Array side requests and data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arr_rd_req <= 1'b0;
      arr_pgm_req <= 1'b0;
      arr_page_addr <= 32'h0;
      arr_wdata <= '0;
    end else begin
      arr_rd_req <= (state_ff == FPBW_PG_RD);
      arr_pgm_req <= (state_ff == FPBW_PGM);
      arr_page_addr <= cur_page_ff;
      if (state_ff == FPBW_PGM) begin
        for (int i = 0; i < PG_BYTES; i++) arr_wdata[i*8 +: 8] <= page_ff[i];
      end
    end
  end

  assign wr_status = status_ff;
  assign wr_done = done_ff | refuse_ff;
endmodule : fpbw_write_buffer

// *** fpbw_write_buffer_asserts.sv ***
// Checker watching the write buffer ports
`timescale 1ns/1ps
module fpbw_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_valid,
  input wire logic wr_ready,
  input wire logic [1:0] wr_status,
  input wire logic wr_done,
  input wire logic arr_rd_req,
  input wire logic arr_pgm_req,
  input wire logic [31:0] arr_page_addr,
  input wire logic arr_ack
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic rd_pend_ff; // Page fetch outstanding at the array
  // Track fetch from request to answer; a program ack also clears it, they never overlap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rd_pend_ff <= 1'b0;
    else if (arr_ack) rd_pend_ff <= 1'b0;
    else if (arr_rd_req) rd_pend_ff <= 1'b1;
  end
  rd_pulse_a: assert property (arr_rd_req |=> !arr_rd_req) else $error("fetch request not a pulse");
  fetch_hold_a: assert property (rd_pend_ff |-> !wr_done && !wr_ready) else $error("write ended during fetch");
  fill_merge_a: assert property (rd_pend_ff && arr_ack |-> ##[1:4] wr_done)
    else $error("no completion after page fill");
  take_answer_a: assert property (wr_valid && wr_ready |-> ##[1:4] (wr_done || arr_rd_req))
    else $error("write took no action");
  status_code_a: assert property (wr_done |-> wr_status != 2'h2) else $error("unknown status code");
  req_excl_a: assert property (!(arr_rd_req && arr_pgm_req)) else $error("fetch and program together");
  addr_hold_a: assert property (rd_pend_ff |-> $stable(arr_page_addr)) else $error("page moved in fetch");
  idle_nofetch_a: assert property (wr_ready |-> !arr_rd_req) else $error("fetch while idle");
endmodule : fpbw_chk
bind fpbw_write_buffer fpbw_chk u_chk (.pclk, .presetn, .wr_valid, .wr_ready, .wr_status, .wr_done,
  .arr_rd_req, .arr_pgm_req, .arr_page_addr, .arr_ack);

// *** fpbw_array_model.sv ***
// Behavioural flash array serving page fetch and program
`timescale 1ns/1ps
module fpbw_array_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic rd_req,
  input wire logic pgm_req,
  input wire logic [31:0] page,
  input wire logic [3:0] dly,
  output logic ack,
  output logic [1023:0] rdata
);
  logic busy_ff; // Operation in flight
  logic rd_ff; // Flight is a fetch
  logic [3:0] cnt_ff; // Cycles left before the answer
  logic [31:0] pg_ff; // Page being served
  // Answer dly+1 cycles after the request; outside ack the data churns so stale data never looks valid
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_ff <= 1'b0;
      ack <= 1'b0;
      rdata <= '0;
    end else if (rd_req || pgm_req) begin
      busy_ff <= 1'b1;
      rd_ff <= rd_req;
      cnt_ff <= dly;
      pg_ff <= page;
      ack <= 1'b0;
      rdata <= ~rdata;
    end else if (busy_ff && cnt_ff == 4'h0) begin
      busy_ff <= 1'b0;
      ack <= 1'b1;
      for (int i = 0; i < 128; i++) rdata[8*i+:8] <= rd_ff ? 8'(i + 3 * pg_ff) : ~rdata[8*i+:8];
    end else begin
      cnt_ff <= cnt_ff - 4'h1;
      ack <= 1'b0;
      rdata <= ~rdata;
    end
  end
endmodule : fpbw_array_model

// *** tb_flash_page_block_write_buffer.sv ***
// Self-checking bench for the flash page/block write buffer
`timescale 1ns/1ps
module tb_flash_page_block_write_buffer;
  import fpbw_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, wr_valid = 0;
  logic [31:0] paddr = 0, pwdata = 0, wr_addr = 0, wr_data = 0, r, prdata, page_addr;
  logic [1:0] sz = 0, wr_status;
  logic [3:0] dly = 4'h6; // Array answer delay, slow first
  logic pready, pslverr, serr, wr_ready, wr_done, rd_req, pgm_req, ack, irq;
  logic [1023:0] wdata, rdata;
  logic [7:0] pg_exp [128]; // Expected page buffer image
  int miscompares = 0, n_tests = 0;
  always #2 pclk = ~pclk;
  fpbw_write_buffer dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .wr_valid, .wr_ready, .wr_addr, .write_data_in(wr_data), .transfer_size_sel(sz), .wr_status,
    .wr_done, .arr_rd_req(rd_req), .arr_pgm_req(pgm_req), .arr_page_addr(page_addr), .arr_wdata(wdata),
    .arr_ack(ack), .arr_rdata(rdata), .irq);
  fpbw_array_model u_arr (.pclk, .presetn, .rd_req, .pgm_req, .page(page_addr), .dly, .ack, .rdata);
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // One APB transfer, held until pready is sampled high
  // No cycle limit here: only the watchdog ends a wait
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  function automatic void fill(input int p);
    for (int i = 0; i < 128; i++) pg_exp[i] = 8'(i + 3 * p);
  endfunction : fill
  // User write; merges accepted bytes into the expected image
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] s, input logic [1:0] st);
    int o = int'(a[6:0] & ~7'(s[1] ? 3 : s));
    @(posedge pclk);
    wr_valid <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
    sz <= s;
    do @(posedge pclk); while (wr_ready !== 1'b1);
    wr_valid <= 1'b0;
    do @(posedge pclk); while (wr_done !== 1'b1);
    chk("wr_status", 32'(wr_status), 32'(st));
    if (st == 2'h0) for (int i = 0; i < (s[1] ? 4 : s + 1); i++) pg_exp[o+i] = d[8*i+:8];
  endtask : wr
  // Program request; the page handed to the array must match the merged image
  task automatic pgm(input logic [31:0] ctl, input logic [31:0] pg);
    apb(1'b1, 32'h4, ctl);
    do @(posedge pclk); while (pgm_req !== 1'b1);
    chk("pgm_page", page_addr, pg);
    for (int i = 0; i < 32; i++)
      chk("pgm_data", wdata[32*i+:32], {pg_exp[4*i+3], pg_exp[4*i+2], pg_exp[4*i+1], pg_exp[4*i]});
    do @(posedge pclk); while (irq !== 1'b1);
  endtask : pgm
  task automatic t_merge();
    fill(2);
    wr(32'h105, 32'h0000_00a5, 2'h0, 2'h0);
    wr(32'h111, 32'h0000_b6c7, 2'h1, 2'h0);
    wr(32'h112, 32'h0000_00d8, 2'h0, 2'h0);
    wr(32'h123, 32'h1234_5678, 2'h2, 2'h0);
    wr(32'h146, 32'h9abc_def0, 2'h3, 2'h0);
    apb(1'b1, 32'h10, 32'h4);
    pgm(32'h4, 32'h2);
    chk("irq", 32'(irq), 32'h1);
    apb(1'b0, 32'h8, 32'h0);
    chk("irq_stat", r, 32'h5);
    apb(1'b1, 32'hc, 32'h7);
    apb(1'b0, 32'h8, 32'h0);
    chk("irq_clr", r, 32'h0);
    chk("irq_low", 32'(irq), 32'h0);
    $display("t_merge done");
  endtask : t_merge
  task automatic t_guard();
    apb(1'b1, 32'h4, 32'h1);
    wr(32'h107, 32'h0000_005a, 2'h0, 2'h0);
    wr(32'h180, 32'h0000_0011, 2'h0, 2'h3);
    apb(1'b0, 32'h0, 32'h0);
    chk("status_guard", r & 32'h3, 32'h3);
    apb(1'b1, 32'h4, 32'h3);
    fill(3);
    dly <= 4'h0;
    wr(32'h181, 32'h0000_0022, 2'h0, 2'h0);
    $display("t_guard done");
  endtask : t_guard
  task automatic t_lock();
    pgm(32'hd, 32'h3);
    apb(1'b0, 32'h14, 32'h0);
    chk("lock_bits", r, 32'h8);
    apb(1'b1, 32'h4, 32'h5);
    apb(1'b0, 32'h0, 32'h0);
    chk("status_lock", r & 32'h3, 32'h1);
    wr(32'h190, 32'h0000_0033, 2'h0, 2'h1);
    apb(1'b1, 32'h4, 32'h11);
    apb(1'b0, 32'h14, 32'h0);
    chk("unlock_bits", r, 32'h0);
    fill(4);
    wr(32'h200, 32'h0000_0044, 2'h0, 2'h0);
    apb(1'b0, 32'h20, 32'h0);
    chk("unmapped", {r[30:0], serr}, 32'h1);
    $display("t_lock done");
  endtask : t_lock
  task automatic close_out();
    $display("Counts: %0d checks, %0d mismatches", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_merge();
    t_guard();
    t_lock();
    close_out();
  end
  // Watchdog: the tests need a few hundred cycles at most
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    close_out();
  end
endmodule : tb_flash_page_block_write_buffer
